// ===== logic/sys_cmd_pkg.sv
/*
 Shared constants and carriers for the optional system command selection
 and snoop reply formatting logic.
 Assumes one clock domain and that callers reference items as sys_cmd_pkg::name.
*/
package sys_cmd_pkg;
    localparam int CMD_W = 5;
    localparam int BUS_W = 15;
    localparam int ID_W = 3;
    localparam int BEATS = 4;

    // Outgoing command codes
    localparam logic [CMD_W-1:0] CMD_PROBE_REPLY = 5'h01;
    localparam logic [CMD_W-1:0] CMD_VICTIM_WB = 5'h04;
    localparam logic [CMD_W-1:0] CMD_CLEAN_VICTIM = 5'h05;
    localparam logic [CMD_W-1:0] CMD_EVICT = 5'h06;
    localparam logic [CMD_W-1:0] CMD_BARRIER = 5'h07;
    localparam logic [CMD_W-1:0] CMD_READ = 5'h10;
    localparam logic [CMD_W-1:0] CMD_READ_MOD = 5'h11;
    localparam logic [CMD_W-1:0] CMD_READ_SPEC = 5'h14;
    localparam logic [CMD_W-1:0] CMD_READ_MOD_SPEC = 5'h15;
    localparam logic [CMD_W-1:0] CMD_READ_VIC = 5'h18;
    localparam logic [CMD_W-1:0] CMD_READ_MOD_VIC = 5'h19;
    localparam logic [CMD_W-1:0] CMD_ITD_VIC = 5'h1b;
    localparam logic [CMD_W-1:0] CMD_CLEAN_TO_DIRTY = 5'h1c;
    localparam logic [CMD_W-1:0] CMD_SHARED_TO_DIRTY = 5'h1d;
    localparam logic [CMD_W-1:0] CMD_STC_TO_DIRTY = 5'h1e;
    localparam logic [CMD_W-1:0] CMD_ITD = 5'h1f;

    // Write hint mode field
    localparam int WH_ENABLE_BIT = 0;
    localparam logic [1:0] WH_INTERNAL = 2'h1;
    localparam logic [1:0] WH_EXTERNAL = 2'h3;

    // Set-modified acknowledge select bit positions
    localparam int SD_CLEAN_BIT = 0;
    localparam int SD_CLEAN_SHARED_BIT = 1;
    localparam int SD_DIRTY_SHARED_BIT = 2;

    // Probe status encodings
    localparam logic [1:0] PS_HIT_CLEAN = 2'h0;
    localparam logic [1:0] PS_HIT_SHARED = 2'h1;
    localparam logic [1:0] PS_HIT_DIRTY = 2'h2;
    localparam logic [1:0] PS_HIT_SHARED_DIRTY = 2'h3;

    // Fill levels and reset values
    localparam logic LEAD_BIT = 1'b0;
    localparam logic DC_LEVEL = 1'b0;
    localparam logic [BUS_W-1:0] BEAT_IDLE = 15'h0000;
    localparam logic RST_READY = 1'b1;

    typedef enum logic [2:0] {
        K_READ, K_READ_MOD, K_BARRIER, K_WRITE_HINT, K_SET_DIRTY, K_EVICT
    } req_kind_t;

    typedef enum logic [1:0] {L1_CLEAN, L1_CLEAN_SHARED, L1_DIRTY_SHARED} l1_state_t;

    typedef struct packed {
        logic external_barrier_enable;
        logic speculative_read_enable;
        logic read_with_victim_mode;
        logic clean_victim_enable;
        logic evict_enable;
        logic [1:0] write_hint_mode;
        logic [2:0] set_dirty_enable;
        logic conditional_store_notify_enable;
    } cfg_t;

    typedef struct packed {
        logic valid;
        req_kind_t kind;
        logic [BUS_W-1:0] addr;
        logic [BUS_W-1:0] victim_addr;
        l1_state_t l1_state;
        logic conditional_store;
        logic l2_hit;
        logic victim;
        logic victim_dirty;
    } core_req_t;

    typedef struct packed {
        logic valid;
        logic miss;
        logic merged;
        logic cache_hit_pending;
        logic found_dirty;
        logic found_shared;
        logic probe_valid;
        logic victim_sent;
        logic [ID_W-1:0] victim_buffer_id;
        logic miss_entry_sent;
        logic [ID_W-1:0] miss_entry_id;
    } probe_t;
endpackage

// ===== logic/sys_cmd_options_probe_reply.sv
/*
 Chooses the optional commands sent on the system command port for core
 requests, and formats the four-beat snoop reply for resolved probes.
 Assumes the core holds a request until taken, that probe lookup and miss
 entry matching are done upstream, and that flow control is handled elsewhere.
*/
module sys_cmd_options_probe_reply (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Configuration
    input wire sys_cmd_pkg::cfg_t i_cfg,
    // Core requests
    input wire sys_cmd_pkg::core_req_t i_req,
    output logic o_req_ready,
    output logic o_int_ack,
    // Probe results
    input wire sys_cmd_pkg::probe_t i_probe,
    output logic o_probe_ready,
    // System command port
    output logic [sys_cmd_pkg::BUS_W-1:0] o_sys_cmd_out_bus,
    output logic o_cmd_valid,
    output logic o_cmd_first
);
    logic [sys_cmd_pkg::BUS_W-1:0] sh_bus_r [sys_cmd_pkg::BEATS];
    logic [sys_cmd_pkg::BEATS-1:0] sh_vld_r;
    logic [sys_cmd_pkg::BEATS-1:0] sh_first_r;
    logic [sys_cmd_pkg::BEATS-1:0] sh_vld_nxt;
    logic [sys_cmd_pkg::BUS_W-1:0] ld_bus [sys_cmd_pkg::BEATS];
    logic [sys_cmd_pkg::BEATS-1:0] ld_vld;
    logic [sys_cmd_pkg::BEATS-1:0] ld_first;
    logic drain;
    logic idle;
    logic take_p;
    logic take_r;
    logic reply;
    logic load;
    logic has_a;
    logic has_b;
    logic rv_a;
    logic int_ack;
    logic vic_ok;
    logic [sys_cmd_pkg::CMD_W-1:0] code_a;
    logic [sys_cmd_pkg::CMD_W-1:0] code_b;
    logic [sys_cmd_pkg::CMD_W-1:0] vic_code;

    function automatic logic [sys_cmd_pkg::BUS_W-1:0] cmd_beat(
        input logic [sys_cmd_pkg::CMD_W-1:0] code,
        input logic rv
    );
        cmd_beat = {sys_cmd_pkg::LEAD_BIT, code, rv, {8{sys_cmd_pkg::DC_LEVEL}}};
    endfunction

    function automatic int sd_sel(input sys_cmd_pkg::l1_state_t st);
        case (st)
            sys_cmd_pkg::L1_CLEAN: sd_sel = sys_cmd_pkg::SD_CLEAN_BIT;
            sys_cmd_pkg::L1_CLEAN_SHARED: sd_sel = sys_cmd_pkg::SD_CLEAN_SHARED_BIT;
            default: sd_sel = sys_cmd_pkg::SD_DIRTY_SHARED_BIT;
        endcase
    endfunction

    function automatic logic [1:0] probe_status(input logic dirty, input logic shared);
        case ({dirty, shared})
            2'h0: probe_status = sys_cmd_pkg::PS_HIT_CLEAN;
            2'h1: probe_status = sys_cmd_pkg::PS_HIT_SHARED;
            2'h2: probe_status = sys_cmd_pkg::PS_HIT_DIRTY;
            default: probe_status = sys_cmd_pkg::PS_HIT_SHARED_DIRTY;
        endcase
    endfunction

    // Only the outgoing beat may remain, so a four-beat load never overwrites a live beat
    function automatic logic has_room(input logic [sys_cmd_pkg::BEATS-1:0] vld);
        has_room = (vld[sys_cmd_pkg::BEATS-1:1] == 3'h0);
    endfunction

    // Picks the plain or modify-intent flavour of a read code by request kind
    function automatic logic [sys_cmd_pkg::CMD_W-1:0] by_kind(
        input sys_cmd_pkg::req_kind_t kind,
        input logic [sys_cmd_pkg::CMD_W-1:0] plain,
        input logic [sys_cmd_pkg::CMD_W-1:0] modify
    );
        by_kind = (kind == sys_cmd_pkg::K_READ_MOD) ? modify : plain;
    endfunction

    // Room opens when at most the outgoing beat remains
    assign drain = has_room(sh_vld_r);
    // Speculation needs a truly empty queue, not just one draining
    assign idle = (sh_vld_r == 4'h0);
    // A refused request gets no signal; the core simply keeps holding it
    assign take_p = i_probe.valid && o_probe_ready;
    // A probe wins the slot; a request seen alongside it must wait
    assign take_r = i_req.valid && o_req_ready && !i_probe.valid;
    assign reply = take_p && !(i_probe.miss || i_probe.merged
                               || i_probe.cache_hit_pending);
    assign load = reply || (take_r && has_a);

    // Command selection for core requests
    always_comb begin
        has_a = 1'b0;
        has_b = 1'b0;
        rv_a = 1'b0;
        int_ack = 1'b0;
        code_a = sys_cmd_pkg::CMD_READ;
        code_b = sys_cmd_pkg::CMD_VICTIM_WB;
        vic_code = i_req.victim_dirty ? sys_cmd_pkg::CMD_VICTIM_WB
                                      : sys_cmd_pkg::CMD_CLEAN_VICTIM;
        vic_ok = i_req.victim && (i_req.victim_dirty || i_cfg.clean_victim_enable);
        case (i_req.kind)
            sys_cmd_pkg::K_READ,
            sys_cmd_pkg::K_READ_MOD: begin
                if (i_cfg.speculative_read_enable && idle) begin
                    has_a = 1'b1;
                    code_a = by_kind(i_req.kind, sys_cmd_pkg::CMD_READ_SPEC,
                                     sys_cmd_pkg::CMD_READ_MOD_SPEC);
                    rv_a = !(i_req.l2_hit || i_cfg.read_with_victim_mode
                             || i_req.victim);
                    has_b = !i_req.l2_hit && vic_ok;
                    code_b = vic_code;
                end else if (i_req.l2_hit) begin
                    int_ack = 1'b1;
                end else if (i_cfg.read_with_victim_mode && vic_ok) begin
                    has_a = 1'b1;
                    code_a = by_kind(i_req.kind, sys_cmd_pkg::CMD_READ_VIC,
                                     sys_cmd_pkg::CMD_READ_MOD_VIC);
                    has_b = 1'b1;
                    code_b = vic_code;
                end else begin
                    has_a = 1'b1;
                    code_a = by_kind(i_req.kind, sys_cmd_pkg::CMD_READ,
                                     sys_cmd_pkg::CMD_READ_MOD);
                    has_b = vic_ok;
                    code_b = vic_code;
                end
            end
            sys_cmd_pkg::K_BARRIER: begin
                has_a = i_cfg.external_barrier_enable;
                code_a = sys_cmd_pkg::CMD_BARRIER;
                int_ack = !i_cfg.external_barrier_enable;
            end
            sys_cmd_pkg::K_WRITE_HINT: begin
                if (!i_cfg.write_hint_mode[sys_cmd_pkg::WH_ENABLE_BIT]) begin
                    has_a = 1'b1;
                    code_a = sys_cmd_pkg::CMD_READ_MOD;
                end else if (i_cfg.write_hint_mode == sys_cmd_pkg::WH_INTERNAL) begin
                    int_ack = 1'b1;
                end else if (i_cfg.read_with_victim_mode && vic_ok) begin
                    has_a = 1'b1;
                    code_a = sys_cmd_pkg::CMD_ITD_VIC;
                    has_b = 1'b1;
                    code_b = vic_code;
                end else begin
                    has_a = 1'b1;
                    code_a = sys_cmd_pkg::CMD_ITD;
                    has_b = vic_ok;
                    code_b = vic_code;
                end
            end
            sys_cmd_pkg::K_SET_DIRTY: begin
                if (i_cfg.set_dirty_enable[sd_sel(i_req.l1_state)]) begin
                    has_a = 1'b1;
                    if (i_req.conditional_store && i_cfg.conditional_store_notify_enable) begin
                        code_a = sys_cmd_pkg::CMD_STC_TO_DIRTY;
                    end else if (i_req.l1_state == sys_cmd_pkg::L1_CLEAN) begin
                        code_a = sys_cmd_pkg::CMD_CLEAN_TO_DIRTY;
                    end else begin
                        code_a = sys_cmd_pkg::CMD_SHARED_TO_DIRTY;
                    end
                end else begin
                    int_ack = 1'b1;
                end
            end
            sys_cmd_pkg::K_EVICT: begin
                has_a = i_cfg.evict_enable;
                code_a = sys_cmd_pkg::CMD_EVICT;
                has_b = i_cfg.evict_enable && vic_ok;
                code_b = vic_code;
                int_ack = !i_cfg.evict_enable;
            end
            default: begin
                int_ack = 1'b1;
            end
        endcase
    end

    // Beats to load; a command pair sits in one load so nothing can split it
    always_comb begin
        if (reply) begin
            ld_bus[0] = {sys_cmd_pkg::LEAD_BIT, sys_cmd_pkg::CMD_PROBE_REPLY,
                         probe_status(i_probe.found_dirty, i_probe.found_shared),
                         i_probe.probe_valid, i_probe.victim_sent,
                         i_probe.victim_buffer_id,
                         {2{sys_cmd_pkg::DC_LEVEL}}};
            ld_bus[1] = {sys_cmd_pkg::LEAD_BIT, i_probe.miss_entry_sent,
                         i_probe.miss_entry_id,
                         {10{sys_cmd_pkg::DC_LEVEL}}};
            ld_bus[2] = sys_cmd_pkg::BEAT_IDLE;
            ld_bus[3] = sys_cmd_pkg::BEAT_IDLE;
            ld_vld = 4'hf;
            ld_first = 4'h1;
        end else begin
            ld_bus[0] = cmd_beat(code_a, rv_a);
            ld_bus[1] = i_req.addr;
            ld_bus[2] = has_b ? cmd_beat(code_b, 1'b0) : sys_cmd_pkg::BEAT_IDLE;
            ld_bus[3] = has_b ? i_req.victim_addr : sys_cmd_pkg::BEAT_IDLE;
            ld_vld = {has_b, has_b, has_a, has_a};
            ld_first = {1'b0, has_b, 1'b0, has_a};
        end
    end

    always_comb begin
        if (load) begin
            sh_vld_nxt = ld_vld;
        end else begin
            sh_vld_nxt = {1'b0, sh_vld_r[sys_cmd_pkg::BEATS-1:1]};
        end
    end

    // Beat shifter
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < sys_cmd_pkg::BEATS; i++) begin
                sh_bus_r[i] <= sys_cmd_pkg::BEAT_IDLE;
            end
            sh_vld_r <= 4'h0;
            sh_first_r <= 4'h0;
        end else if (load) begin
            for (int i = 0; i < sys_cmd_pkg::BEATS; i++) begin
                sh_bus_r[i] <= ld_bus[i];
            end
            sh_vld_r <= ld_vld;
            sh_first_r <= ld_first;
        end else begin
            for (int i = 0; i < sys_cmd_pkg::BEATS - 1; i++) begin
                sh_bus_r[i] <= sh_bus_r[i+1];
            end
            sh_bus_r[sys_cmd_pkg::BEATS-1] <= sys_cmd_pkg::BEAT_IDLE;
            sh_vld_r <= sh_vld_nxt;
            sh_first_r <= {1'b0, sh_first_r[sys_cmd_pkg::BEATS-1:1]};
        end
    end

    // Command port outputs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sys_cmd_out_bus <= sys_cmd_pkg::BEAT_IDLE;
            o_cmd_valid <= 1'b0;
            o_cmd_first <= 1'b0;
        end else if (drain) begin
            o_sys_cmd_out_bus <= sh_vld_r[0] ? sh_bus_r[0] : sys_cmd_pkg::BEAT_IDLE;
            o_cmd_valid <= sh_vld_r[0];
            o_cmd_first <= sh_vld_r[0] && sh_first_r[0];
        end else begin
            o_sys_cmd_out_bus <= sh_bus_r[0];
            o_cmd_valid <= sh_vld_r[0];
            o_cmd_first <= sh_first_r[0];
        end
    end

    // Ready mirrors room in the shifter one cycle ahead
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_req_ready <= sys_cmd_pkg::RST_READY;
            o_probe_ready <= sys_cmd_pkg::RST_READY;
        end else begin
            o_req_ready <= has_room(sh_vld_nxt);
            o_probe_ready <= has_room(sh_vld_nxt);
        end
    end

    // Internal acknowledge for requests that need no command
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_int_ack <= 1'b0;
        end else begin
            o_int_ack <= take_r && int_ack;
        end
    end
endmodule // sys_cmd_options_probe_reply

// ===== dv/sys_cmd_opt_chk.sv
/* Concurrent checks on the system command port and snoop reply layout.
   Assumes binding to the design top, one clock, async active-low reset. */
module sys_cmd_opt_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Design inputs
    input wire sys_cmd_pkg::cfg_t i_cfg,
    input wire sys_cmd_pkg::core_req_t i_req,
    input wire sys_cmd_pkg::probe_t i_probe,
    // Design outputs
    input wire logic o_req_ready,
    input wire logic o_int_ack,
    input wire logic o_probe_ready,
    input wire logic [sys_cmd_pkg::BUS_W-1:0] o_sys_cmd_out_bus,
    input wire logic o_cmd_valid,
    input wire logic o_cmd_first
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    logic pt, pd, rt;
    logic [4:0] code;
    assign code = o_sys_cmd_out_bus[13:9];
    assign rt = i_req.valid && o_req_ready && !i_probe.valid;
    assign pd = i_probe.valid && o_probe_ready;
    assign pt = pd && !i_probe.miss && !i_probe.merged && !i_probe.cache_hit_pending;
    sequence s_head(logic [4:0] c);
        o_cmd_first && code == c;
    endsequence
    sequence s_cmd(logic [4:0] c);
        s_head(c) ##1 (o_cmd_valid && !o_cmd_first);
    endsequence
    a_reply_beats: assert property (pt |-> ##2 s_cmd(sys_cmd_pkg::CMD_PROBE_REPLY)
        ##1 (o_cmd_valid && !o_cmd_first)[*2]) else $error("snoop reply beats wrong");
    a_reply_status: assert property (pt |-> ##2 o_sys_cmd_out_bus[8:7] ==
        {$past(i_probe.found_dirty, 2), $past(i_probe.found_shared, 2)})
        else $error("probe status wrong");
    a_reply_flags: assert property (pt |-> ##2 o_sys_cmd_out_bus[6:2] ==
        {$past(i_probe.probe_valid, 2), $past(i_probe.victim_sent, 2),
        $past(i_probe.victim_buffer_id, 2)}) else $error("reply flags wrong");
    a_reply_miss: assert property (pt |-> ##3 o_sys_cmd_out_bus == {1'b0,
        $past(i_probe.miss_entry_sent, 3), $past(i_probe.miss_entry_id, 3), 10'h000})
        else $error("reply miss entry wrong");
    a_reply_fill: assert property (pt |-> ##2 o_sys_cmd_out_bus[1:0] == 2'h0
        ##2 o_sys_cmd_out_bus == 15'h0000 ##1 o_sys_cmd_out_bus == 15'h0000)
        else $error("reply fill not zero");
    a_probe_drop: assert property (pd && !pt |-> ##2 !o_cmd_first)
        else $error("dropped probe replied");
    a_barrier_route: assert property (rt && i_req.kind == sys_cmd_pkg::K_BARRIER |->
        if (i_cfg.external_barrier_enable) ##2 s_cmd(sys_cmd_pkg::CMD_BARRIER)
        else ##1 o_int_ack) else $error("barrier routing wrong");
    a_victim_pair: assert property (rt && i_req.kind == sys_cmd_pkg::K_READ
        && i_cfg.read_with_victim_mode && !i_cfg.speculative_read_enable && i_req.victim
        && i_req.victim_dirty && !i_req.l2_hit |-> ##2 s_cmd(sys_cmd_pkg::CMD_READ_VIC)
        ##1 s_cmd(sys_cmd_pkg::CMD_VICTIM_WB)) else $error("victim not adjacent");
    a_hint_ext: assert property (rt && i_req.kind == sys_cmd_pkg::K_WRITE_HINT
        && i_cfg.write_hint_mode == sys_cmd_pkg::WH_EXTERNAL && !i_req.victim
        |-> ##2 s_head(sys_cmd_pkg::CMD_ITD)) else $error("write hint not external");
    a_hint_modify: assert property (rt && i_req.kind == sys_cmd_pkg::K_WRITE_HINT
        && !i_cfg.write_hint_mode[0] |-> ##2 s_cmd(sys_cmd_pkg::CMD_READ_MOD))
        else $error("write hint not converted");
    a_stc_notify: assert property (rt && i_req.kind == sys_cmd_pkg::K_SET_DIRTY
        && i_req.conditional_store && i_cfg.conditional_store_notify_enable
        && i_cfg.set_dirty_enable == 3'h7 |-> ##2 s_head(sys_cmd_pkg::CMD_STC_TO_DIRTY))
        else $error("conditional store code wrong");
endmodule // sys_cmd_opt_chk

bind sys_cmd_options_probe_reply sys_cmd_opt_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cfg(i_cfg), .i_req(i_req), .i_probe(i_probe), .o_req_ready(o_req_ready),
    .o_int_ack(o_int_ack), .o_probe_ready(o_probe_ready),
    .o_sys_cmd_out_bus(o_sys_cmd_out_bus), .o_cmd_valid(o_cmd_valid), .o_cmd_first(o_cmd_first));

// ===== dv/sys_chipset_model.sv
/* Chipset side of the command port: logs every beat and counts replies that call
   for a data fetch. Assumes the port never pushes back, so it only listens. */
module sys_chipset_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Command port
    input wire logic [sys_cmd_pkg::BUS_W-1:0] i_bus,
    input wire logic i_valid,
    input wire logic i_first
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [sys_cmd_pkg::BUS_W-1:0] beats[$];
    int fetch_count;
    // Buffer id is trusted only with move-data or victim-sent set
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            beats.delete();
            fetch_count = 0;
        end else if (i_valid === 1'b1) begin
            beats.push_back(i_bus);
            if (i_first && i_bus[13:9] == sys_cmd_pkg::CMD_PROBE_REPLY
                && (i_bus[6] || i_bus[5])) begin
                fetch_count++;
            end
        end
    end
endmodule // sys_chipset_model

// ===== dv/sys_cmd_options_probe_reply_test.sv
/* Self-checking bench: option routing of core requests and snoop reply layout.
   Assumes the chipset model logs the port; inputs move 1 ns after the edge. */
module sys_cmd_options_probe_reply_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] NONE = 5'h00;
    localparam logic [14:0] ADDR = 15'h1234;
    localparam logic [14:0] VADDR = 15'h2b6e;
    logic i_clk, i_rstn, o_req_ready, o_int_ack, o_probe_ready, o_cmd_valid, o_cmd_first;
    sys_cmd_pkg::cfg_t i_cfg;
    sys_cmd_pkg::core_req_t i_req, r;
    sys_cmd_pkg::probe_t i_probe, p;
    logic [14:0] o_sys_cmd_out_bus;
    int err_count = 0, tests_run = 0, ack_count = 0;
    sys_cmd_options_probe_reply uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg(i_cfg),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_int_ack(o_int_ack), .i_probe(i_probe),
        .o_probe_ready(o_probe_ready), .o_sys_cmd_out_bus(o_sys_cmd_out_bus),
        .o_cmd_valid(o_cmd_valid), .o_cmd_first(o_cmd_first));
    sys_chipset_model partner (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(o_sys_cmd_out_bus),
        .i_valid(o_cmd_valid), .i_first(o_cmd_first));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_int_ack === 1'b1) ack_count++;
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [14:0] hdr(input logic [4:0] c, input logic rv);
        return {sys_cmd_pkg::LEAD_BIT, c, rv, 8'h00};
    endfunction
    function automatic sys_cmd_pkg::core_req_t mk(input sys_cmd_pkg::req_kind_t k);
        mk = '0;
        mk.kind = k;
        mk.addr = ADDR;
        mk.victim_addr = VADDR;
    endfunction
    // Valid is held until ready is seen high before an edge; only one of request or probe is driven
    task automatic launch(input logic is_probe);
        int n;
        n = 0;
        partner.beats.delete();
        ack_count = 0;
        r.valid = !is_probe;
        p.valid = is_probe;
        i_req = r;
        i_probe = p;
        while (o_req_ready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                $display("[ERR] %0t request never taken", $time);
                complete_run();
            end
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1;
        i_req.valid = 1'b0;
        i_probe.valid = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic expect_cmds(input logic [4:0] c1, input logic [4:0] c2, input logic rv);
        logic [14:0] e[$];
        if (c1 != NONE) e = '{hdr(c1, rv), ADDR};
        if (c2 != NONE) e = {e, hdr(c2, 1'b0), VADDR};
        check(15'(partner.beats.size()), 15'(e.size()));
        check(15'(ack_count), (c1 == NONE) ? 15'h0001 : 15'h0000);
        foreach (e[i]) check(partner.beats[i], e[i]);
    endtask
    task automatic t_barrier_hint();
        i_cfg = '0;
        r = mk(sys_cmd_pkg::K_BARRIER);
        launch(1'b0);
        expect_cmds(NONE, NONE, 1'b0);
        i_cfg.external_barrier_enable = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_BARRIER, NONE, 1'b0);
        for (int m = 0; m < 4; m++) begin
            i_cfg = '0;
            i_cfg.write_hint_mode = 2'(m);
            r = mk(sys_cmd_pkg::K_WRITE_HINT);
            launch(1'b0);
            if (m == 1) expect_cmds(NONE, NONE, 1'b0);
            else if (m == 3) expect_cmds(sys_cmd_pkg::CMD_ITD, NONE, 1'b0);
            else expect_cmds(sys_cmd_pkg::CMD_READ_MOD, NONE, 1'b0);
        end
        $display("Barrier and write hint test done");
    endtask
    task automatic t_set_dirty();
        for (int s = 0; s < 3; s++) begin
            for (int b = 0; b < 3; b++) begin
                i_cfg = '0;
                i_cfg.set_dirty_enable = 3'(1 << b);
                r = mk(sys_cmd_pkg::K_SET_DIRTY);
                r.l1_state = sys_cmd_pkg::l1_state_t'(s);
                launch(1'b0);
                if (b != s) expect_cmds(NONE, NONE, 1'b0);
                else if (s == 0)
                    expect_cmds(sys_cmd_pkg::CMD_CLEAN_TO_DIRTY, NONE, 1'b0);
                else expect_cmds(sys_cmd_pkg::CMD_SHARED_TO_DIRTY, NONE, 1'b0);
            end
        end
        r.conditional_store = 1'b1;
        i_cfg.set_dirty_enable = 3'h7;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_SHARED_TO_DIRTY, NONE, 1'b0);
        i_cfg.conditional_store_notify_enable = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_STC_TO_DIRTY, NONE, 1'b0);
        $display("Set dirty test done");
    endtask
    task automatic t_victim_spec();
        i_cfg = '0;
        i_cfg.read_with_victim_mode = 1'b1;
        r = mk(sys_cmd_pkg::K_READ);
        r.victim = 1'b1;
        r.victim_dirty = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_VIC, sys_cmd_pkg::CMD_VICTIM_WB, 1'b0);
        r.victim_dirty = 1'b0;
        i_cfg.clean_victim_enable = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_VIC, sys_cmd_pkg::CMD_CLEAN_VICTIM, 1'b0);
        r.kind = sys_cmd_pkg::K_EVICT;
        i_cfg.evict_enable = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_EVICT, sys_cmd_pkg::CMD_CLEAN_VICTIM, 1'b0);
        i_cfg = '0;
        i_cfg.speculative_read_enable = 1'b1;
        r = mk(sys_cmd_pkg::K_READ);
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_SPEC, NONE, 1'b1);
        r.l2_hit = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_SPEC, NONE, 1'b0);
        r.kind = sys_cmd_pkg::K_READ_MOD;
        r.l2_hit = 1'b0;
        r.victim = 1'b1;
        r.victim_dirty = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_MOD_SPEC, sys_cmd_pkg::CMD_VICTIM_WB, 1'b0);
        i_cfg.speculative_read_enable = 1'b0;
        i_cfg.read_with_victim_mode = 1'b1;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ_MOD_VIC, sys_cmd_pkg::CMD_VICTIM_WB, 1'b0);
        r.kind = sys_cmd_pkg::K_WRITE_HINT;
        r.victim_dirty = 1'b0;
        i_cfg.clean_victim_enable = 1'b1;
        i_cfg.write_hint_mode = sys_cmd_pkg::WH_EXTERNAL;
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_ITD_VIC, sys_cmd_pkg::CMD_CLEAN_VICTIM, 1'b0);
        i_cfg = '0;
        r = mk(sys_cmd_pkg::K_READ);
        launch(1'b0);
        expect_cmds(sys_cmd_pkg::CMD_READ, NONE, 1'b0);
        r.l2_hit = 1'b1;
        launch(1'b0);
        expect_cmds(NONE, NONE, 1'b0);
        $display("Victim and speculative test done");
    endtask
    task automatic t_probe();
        for (int s = 0; s < 7; s++) begin
            p = '0;
            p.found_dirty = s[1];
            p.found_shared = s[0];
            p.probe_valid = s[0];
            p.victim_sent = s[1];
            p.victim_buffer_id = 3'(s + 3);
            p.miss_entry_sent = ~s[0];
            p.miss_entry_id = 3'(7 - s);
            p.miss = (s == 4);
            p.merged = (s == 5);
            p.cache_hit_pending = (s == 6);
            launch(1'b1);
            if (s > 3) check(15'(partner.beats.size()), 15'h0000);
            else begin
                check(partner.beats[0], {1'b0, sys_cmd_pkg::CMD_PROBE_REPLY, 2'(s), s[0], s[1],
                    3'(s + 3), 2'h0});
                check(partner.beats[1], {1'b0, ~s[0], 3'(7 - s), 10'h000});
                check(partner.beats[2] | partner.beats[3], 15'h0000);
                check(15'(partner.beats.size()), 15'h0004);
            end
        end
        check(15'(partner.fetch_count), 15'h0003);
        $display("Probe reply test done");
    endtask
    initial begin
        i_rstn = 1'b0;
        i_cfg = '0;
        i_req = '0;
        i_probe = '0;
        r = '0;
        p = '0;
        repeat (8) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        check(o_sys_cmd_out_bus, 15'h0000);
        check(15'({o_req_ready, o_probe_ready, o_cmd_valid, o_cmd_first, o_int_ack}),
            15'h0018);
        t_barrier_hint();
        t_set_dirty();
        t_victim_spec();
        t_probe();
        complete_run();
    end
endmodule // sys_cmd_options_probe_reply_test
